// >>> hdl/ocs_regs.vh
// register map, field positions, reset values and timing counts of the oscillator and clock switch block
// assumes a 125 MHz register clock and 32-bit AXI4-Lite access
`ifndef OCS_REGS_VH
`define OCS_REGS_VH
// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define OCS_ADDR_TUNE      12'h090
`define OCS_ADDR_CTRL      12'h094
// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define OCS_CTRL_IFS_HI    6
`define OCS_CTRL_IFS_LO    4
`define OCS_CTRL_PSTABLE   3
`define OCS_CTRL_FSTABLE   2
`define OCS_CTRL_SCS_HI    1
`define OCS_CTRL_SCS_LO    0
`define OCS_TUNE_W         6
`define OCS_IFS_RST        3'h0
`define OCS_SCS_RST        2'h0
`define OCS_TUNE_RST       6'h00
// ---------------------------------------------------------------
// source select codes
// ---------------------------------------------------------------
`define OCS_SRC_PRI        2'h0
`define OCS_SRC_SEC        2'h1
`define OCS_SRC_INT        2'h2
`define OCS_SRC_RSV        2'h3
`define OCS_IFS_SLOW       3'h0
`define OCS_IFS_FAST       3'h7
// ---------------------------------------------------------------
// primary oscillator mode codes
// ---------------------------------------------------------------
`define OCS_MODE_LP        3'h0
`define OCS_MODE_XT        3'h1
`define OCS_MODE_HS        3'h2
`define OCS_MODE_RC        3'h3
`define OCS_MODE_RCIO      3'h4
`define OCS_MODE_INT_CLOCK_OUTPUT  3'h5
`define OCS_MODE_INT_IO    3'h6
`define OCS_MODE_ECIO      3'h7
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define OCS_OST_COUNT      11'h400
`define OCS_SWITCH_FALLS   4'h8
`define OCS_CLK_MHZ        125
`define OCS_FSTABLE_US     4000
`define OCS_FSTABLE_CYC    20'h7A120  // 4000 us at 125 MHz, sized to the settle counter
`define OCS_RESP_OKAY      2'h0
`define OCS_RESP_SLVERR    2'h2
`endif

// >>> hdl/ocs_clock_switch.v
// oscillator control: tuning and control registers, clock source switching, start-up timing
// assumes every oscillator arrives as a one-cycle falling-edge strobe synchronous to clk_in
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ocs_regs.vh"

// What this block does
// - fast source 8 MHz, postscaler 125 kHz-8 MHz
// - slow rc on when selected or needed
// - frequency field codes 000 slow to 111 fast
// - frequency write changes internal output after a clock switch
// - clkout mode drives sysclk/4, pin7 general I/O
// - all-io mode: both oscillator pins general I/O
// - tune value two's complement, centre at zero
// - tune settles silently, no completion flag
// - source select: primary, secondary, internal, reserved
// - any reset forces source select to primary
// - primary stable flag after start-up on primary
// - flag resets low with two-speed crystal
// - status bit 2 shows fast source stable
// - failsafe drops failed oscillator to slow rc
// - two-speed reset starts slow, then primary
// - two-speed wake waits start-up timer plus eight
// - changing source, or frequency while internal, starts a switch
// - no reset switch unless two-speed crystal
// - watchdog off during switch, cleared after
// - start-up count only for crystal targets
// - secondary oscillator keeps running in sleep
// - hold low from SW_FALL entry, eight new falls
// - leaving slow setting restarts 4 ms stable delay
module ocs_clock_switch #(
  parameter [19:0] FSTABLE_CYC = `OCS_FSTABLE_CYC  // fast source settle time in clk_in cycles
) (
  input  wire        clk_in,                // register clock, 125 MHz
  input  wire        srst_in,               // synchronous reset, active high
  input  wire        ce_in,                 // clock enable, freezes all state when low
  // axi4-lite slave
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // configuration and events
  input  wire [2:0]  primary_mode_in,       // configured primary oscillator mode
  input  wire        two_speed_en_in,       // two-speed start-up enabled
  input  wire        failsafe_monitor_enable_in,
  input  wire        pwrt_en_in,            // power-up timer enabled
  input  wire        wdt_en_in,             // watchdog enabled
  input  wire        sleep_in,              // device sleeping
  input  wire        wake_in,               // interrupt or watchdog wake-up pulse
  input  wire        prim_fail_in,          // primary oscillator failure detected
  input  wire        sec_fail_in,           // secondary oscillator failure detected
  input  wire        sec_osc_en_in,         // software enable of the secondary oscillator
  // oscillator falling-edge strobes
  input  wire        prim_fall_in,
  input  wire        sec_fall_in,
  input  wire        slow_rc_fall_in,       // 31.25 kHz source
  input  wire        fast_osc_fall_in,      // 8 MHz source
  // outputs to the clocking tree
  output reg         sys_tick_out,          // falling-edge strobe of the system clock
  output reg         cpu_hold_out,          // execution held while primary starts
  output reg         slow_rc_en_out,
  output reg         prim_osc_en_out,
  output reg         sec_osc_en_out,
  output reg  [5:0]  tune_value_out,        // trim to both internal oscillators
  output reg         wdt_disable_out,
  output reg         wdt_clear_out,         // one-cycle pulse at switch completion
  // oscillator pins and port a bits
  input  wire        osc_input_pin_in,
  output reg         osc_input_pin_out,
  output reg         osc_input_pin_oe_out,
  input  wire        osc_output_pin_in,
  output reg         osc_output_pin_out,
  output reg         osc_output_pin_oe_out,
  input  wire        port_a_bit_six_out_in, // port logic data and enable
  input  wire        port_a_bit_six_oe_in,
  input  wire        port_a_bit_seven_out_in,
  input  wire        port_a_bit_seven_oe_in,
  output reg         port_a_bit_six_rd_out,
  output reg         port_a_bit_seven_rd_out
);

  // ---------------------------------------------------------------
  // state machine codes
  // ---------------------------------------------------------------
  localparam [1:0] SW_RUN  = 2'h0;  // running from current source
  localparam [1:0] SW_OST  = 2'h1;  // crystal warming, old clock still runs
  localparam [1:0] SW_FALL = 2'h2;  // waiting for a falling edge of old clock
  localparam [1:0] SW_CNT  = 2'h3;  // clock held low, counting new falls

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // crystal modes need the start-up timer
  function is_xtal;
    input [2:0] mode;
    begin
      is_xtal = (mode == `OCS_MODE_LP) || (mode == `OCS_MODE_XT) || (mode == `OCS_MODE_HS);
    end
  endfunction

  // falling-edge strobe of one source at one internal frequency
  function src_fall;
    input [1:0] src;
    input [2:0] freq;
    input       pri;
    input       sec;
    input       slow;
    input       fast;
    input [5:0] pcnt;
    reg   [5:0] mask;
    begin
      mask = 6'h3F >> (freq - 3'h1);  // code 7 passes every strobe, code 1 one in 64
      case (src)
        `OCS_SRC_PRI: src_fall = pri;
        `OCS_SRC_SEC: src_fall = sec;
        default: begin
          if (freq == `OCS_IFS_SLOW) begin
            src_fall = slow;
          end else begin
            // postscaler: divide 8 MHz by 2^(7-freq)
            src_fall = fast && ((pcnt & mask) == mask);
          end
        end
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // registers and state
  // ---------------------------------------------------------------
  reg  [2:0]  ifs;              // internal frequency select
  reg  [1:0]  sysclk_source_select;              // system clock source select
  reg         pstable;          // primary stable flag
  reg         fstable;          // fast source stable flag
  reg         fs_active;        // failsafe has taken over
  reg  [1:0]  cur_src;          // source driving the system clock
  reg  [2:0]  cur_freq;         // internal frequency in use
  reg  [1:0]  tgt_src;          // source being switched to
  reg  [2:0]  tgt_freq;
  reg  [1:0]  sw_state;
  reg  [10:0] ost_cnt;          // start-up timer, counts down 1024 primary falls
  reg  [3:0]  fall_cnt;
  reg  [19:0] fst_cnt;          // fast source settle counter
  reg  [5:0]  psc_cnt;          // postscaler counter on the 8 MHz source
  reg  [1:0]  quarter;          // system clock divide by four
  reg         wake_pend;        // start-up pending after reset or two-speed wake

  wire        ceff = ce_in;
  wire        xtal = is_xtal(primary_mode_in);
  // failsafe forces the slow internal setting without touching the register
  wire [1:0]  req_src  = fs_active ? `OCS_SRC_INT : sysclk_source_select;
  wire [2:0]  req_freq = fs_active ? `OCS_IFS_SLOW : ifs;
  wire [2:0]  req_fe   = (req_src == `OCS_SRC_INT) ? req_freq : `OCS_IFS_SLOW;
  wire [2:0]  cur_fe   = (cur_src == `OCS_SRC_INT) ? cur_freq : `OCS_IFS_SLOW;
  wire        req_diff = (req_src != cur_src) || (req_fe != cur_fe);
  wire        old_fall = src_fall(cur_src, cur_freq, prim_fall_in, sec_fall_in,
                                  slow_rc_fall_in, fast_osc_fall_in, psc_cnt);
  wire        new_fall = src_fall(tgt_src, tgt_freq, prim_fall_in, sec_fall_in,
                                  slow_rc_fall_in, fast_osc_fall_in, psc_cnt);

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  // both write channels taken together, one answer outstanding at a time
  // ready stays low while frozen, so no handshake completes unseen
  wire        wr_go  = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && ceff;
  wire        rd_go  = s_axi_arvalid && !s_axi_rvalid && ceff;
  wire        wr_tun = wr_go && (s_axi_awaddr == `OCS_ADDR_TUNE) && s_axi_wstrb[0];
  wire        wr_ctl = wr_go && (s_axi_awaddr == `OCS_ADDR_CTRL) && s_axi_wstrb[0];
  wire        wr_map = (s_axi_awaddr == `OCS_ADDR_TUNE) || (s_axi_awaddr == `OCS_ADDR_CTRL);
  wire [2:0]  w_ifs  = s_axi_wdata[`OCS_CTRL_IFS_HI:`OCS_CTRL_IFS_LO];
  wire [1:0]  w_scs  = s_axi_wdata[`OCS_CTRL_SCS_HI:`OCS_CTRL_SCS_LO];

  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;

  // write response and read data
  always @(posedge clk_in) begin
    if (srst_in) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `OCS_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `OCS_RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
    end else if (ceff) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `OCS_RESP_OKAY : `OCS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `OCS_RESP_OKAY;
        // unused bits and upper lanes read zero
        case (s_axi_araddr)
          `OCS_ADDR_TUNE: s_axi_rdata <= {26'h0, tune_value_out};
          `OCS_ADDR_CTRL: s_axi_rdata <= {25'h0, ifs, pstable, fstable, sysclk_source_select};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `OCS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // software-writable fields
  // ---------------------------------------------------------------
  // flags are not written here, so writes to them fall away
  always @(posedge clk_in) begin
    if (srst_in) begin
      ifs            <= `OCS_IFS_RST;
      sysclk_source_select            <= `OCS_SCS_RST;
      tune_value_out <= `OCS_TUNE_RST;
    end else if (ceff) begin
      if (wr_tun) begin
        // trim passes straight to the oscillators; settling is silent
        tune_value_out <= s_axi_wdata[`OCS_TUNE_W-1:0];
      end
      if (wr_ctl) begin
        ifs <= w_ifs;
        // reserved code keeps the previous source
        if (w_scs != `OCS_SRC_RSV) begin
          sysclk_source_select <= w_scs;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // failsafe takeover
  // ---------------------------------------------------------------
  // sticky until software writes the control register again or reset
  always @(posedge clk_in) begin
    if (srst_in) begin
      fs_active <= 1'b0;
    end else if (ceff) begin
      if (failsafe_monitor_enable_in &&
          ((cur_src == `OCS_SRC_PRI && prim_fail_in) ||
           (cur_src == `OCS_SRC_SEC && sec_fail_in))) begin
        fs_active <= 1'b1;
      end else if (wr_ctl) begin
        fs_active <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // postscaler and fast source stability
  // ---------------------------------------------------------------
  always @(posedge clk_in) begin
    if (srst_in) begin
      psc_cnt <= 6'h00;
      fstable <= 1'b0;
      fst_cnt <= FSTABLE_CYC;
    end else if (ceff) begin
      if (fast_osc_fall_in) begin
        psc_cnt <= psc_cnt + 6'h01;
      end
      // leaving the slow setting for a fast one restarts the settle delay
      if (wr_ctl && ifs == `OCS_IFS_SLOW && w_ifs != `OCS_IFS_SLOW) begin
        fstable <= 1'b0;
        fst_cnt <= FSTABLE_CYC;
      end else if (fst_cnt != 20'h00000) begin
        fst_cnt <= fst_cnt - 20'h00001;
        if (fst_cnt == 20'h00001) begin
          fstable <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // clock switch sequencer
  // ---------------------------------------------------------------
  // the system clock only ever follows one source's strobes, and is held
  // low from entry to SW_FALL, old fall included, until the eighth new fall, so no short pulse
  always @(posedge clk_in) begin
    if (srst_in) begin
      // two-speed crystal starts on the slow rc and warms the crystal
      cur_src       <= (two_speed_en_in && xtal) ? `OCS_SRC_INT : `OCS_SRC_PRI;
      cur_freq      <= `OCS_IFS_SLOW;
      tgt_src       <= `OCS_SRC_PRI;
      tgt_freq      <= `OCS_IFS_SLOW;
      sw_state      <= SW_RUN;
      ost_cnt       <= 11'h000;
      fall_cnt      <= 4'h0;
      pstable       <= 1'b0;
      cpu_hold_out  <= 1'b0;
      wdt_clear_out <= 1'b0;
      wake_pend     <= 1'b1;
    end else if (ceff) begin
      wdt_clear_out <= 1'b0;
      case (sw_state)
        SW_RUN: begin
          if (wake_pend) begin
            // start-up after reset or wake: timer only for a crystal primary
            wake_pend <= 1'b0;
            if (xtal) begin
              tgt_src      <= `OCS_SRC_PRI;
              tgt_freq     <= `OCS_IFS_SLOW;
              ost_cnt      <= `OCS_OST_COUNT;
              sw_state     <= SW_OST;
              // without two-speed, execution waits for the crystal
              cpu_hold_out <= (cur_src == `OCS_SRC_PRI);
            end else begin
              pstable <= (cur_src == `OCS_SRC_PRI);
            end
          end else if (wake_in && two_speed_en_in && xtal && sysclk_source_select == `OCS_SRC_PRI) begin
            cur_src   <= `OCS_SRC_INT;
            cur_freq  <= `OCS_IFS_SLOW;
            pstable   <= 1'b0;
            wake_pend <= 1'b1;
          end else if (req_diff) begin
            tgt_src  <= req_src;
            tgt_freq <= req_fe;
            pstable  <= 1'b0;
            if (req_src == `OCS_SRC_PRI && xtal) begin
              ost_cnt  <= `OCS_OST_COUNT;
              sw_state <= SW_OST;
            end else begin
              sw_state <= SW_FALL;
            end
          end
        end
        SW_OST: begin
          // old clock keeps running while the crystal starts
          if (prim_fall_in) begin
            ost_cnt <= ost_cnt - 11'h001;
            if (ost_cnt == 11'h001) begin
              sw_state <= cpu_hold_out ? SW_RUN : SW_FALL;
              if (cpu_hold_out) begin
                cpu_hold_out  <= 1'b0;
                pstable       <= 1'b1;
                wdt_clear_out <= 1'b1;
              end
            end
          end
        end
        SW_FALL: begin
          if (old_fall) begin
            fall_cnt <= 4'h0;
            sw_state <= SW_CNT;
          end
        end
        default: begin
          // count eight falls of the requested clock
          if (new_fall) begin
            fall_cnt <= fall_cnt + 4'h1;
            if (fall_cnt == `OCS_SWITCH_FALLS - 4'h1) begin
              cur_src       <= tgt_src;
              cur_freq      <= tgt_freq;
              pstable       <= (tgt_src == `OCS_SRC_PRI) && xtal;
              wdt_clear_out <= 1'b1;
              sw_state      <= SW_RUN;
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // system clock strobe and clock output divider
  // ---------------------------------------------------------------
  always @(posedge clk_in) begin
    if (srst_in) begin
      sys_tick_out <= 1'b0;
      quarter      <= 2'h0;
    end else if (ceff) begin
      // gated low from SW_FALL until the eighth new fall, and while held
      sys_tick_out <= old_fall && (sw_state != SW_CNT) && !cpu_hold_out
                      && !(sw_state == SW_FALL);
      if (sys_tick_out) begin
        quarter <= quarter + 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // oscillator enables and watchdog control
  // ---------------------------------------------------------------
  always @(posedge clk_in) begin
    if (srst_in) begin
      slow_rc_en_out  <= 1'b1;
      prim_osc_en_out <= 1'b1;
      sec_osc_en_out  <= 1'b0;
      wdt_disable_out <= 1'b0;
    end else if (ceff) begin
      slow_rc_en_out  <= (cur_src == `OCS_SRC_INT && cur_freq == `OCS_IFS_SLOW) ||
                         (tgt_src == `OCS_SRC_INT && tgt_freq == `OCS_IFS_SLOW) ||
                         pwrt_en_in || wdt_en_in || two_speed_en_in ||
                         failsafe_monitor_enable_in;
      prim_osc_en_out <= !sleep_in && (cur_src == `OCS_SRC_PRI || tgt_src == `OCS_SRC_PRI ||
                                       sw_state == SW_OST);
      // sleep does not stop the secondary oscillator
      sec_osc_en_out  <= sec_osc_en_in;
      wdt_disable_out <= (sw_state != SW_RUN);
    end
  end

  // ---------------------------------------------------------------
  // oscillator pins
  // ---------------------------------------------------------------
  // pins stay with the analog oscillator except in the internal modes
  always @(posedge clk_in) begin
    if (srst_in) begin
      osc_input_pin_out       <= 1'b0;
      osc_input_pin_oe_out    <= 1'b0;
      osc_output_pin_out      <= 1'b0;
      osc_output_pin_oe_out   <= 1'b0;
      port_a_bit_six_rd_out   <= 1'b0;
      port_a_bit_seven_rd_out <= 1'b0;
    end else if (ceff) begin
      osc_input_pin_out       <= 1'b0;
      osc_input_pin_oe_out    <= 1'b0;
      osc_output_pin_out      <= 1'b0;
      osc_output_pin_oe_out   <= 1'b0;
      port_a_bit_six_rd_out   <= 1'b0;
      port_a_bit_seven_rd_out <= 1'b0;
      case (primary_mode_in)
        `OCS_MODE_INT_CLOCK_OUTPUT: begin
          osc_output_pin_out      <= quarter[1];
          osc_output_pin_oe_out   <= 1'b1;
          osc_input_pin_out       <= port_a_bit_seven_out_in;
          osc_input_pin_oe_out    <= port_a_bit_seven_oe_in;
          port_a_bit_seven_rd_out <= osc_input_pin_in;
        end
        `OCS_MODE_INT_IO: begin
          osc_input_pin_out       <= port_a_bit_seven_out_in;
          osc_input_pin_oe_out    <= port_a_bit_seven_oe_in;
          port_a_bit_seven_rd_out <= osc_input_pin_in;
          osc_output_pin_out      <= port_a_bit_six_out_in;
          osc_output_pin_oe_out   <= port_a_bit_six_oe_in;
          port_a_bit_six_rd_out   <= osc_output_pin_in;
        end
        default: begin
          osc_output_pin_oe_out <= 1'b0;
        end
      endcase
    end
  end

endmodule // ocs_clock_switch

// >>> tb/ocs_props.sv
// port checker for the clock switch, bound onto ocs_clock_switch
`timescale 1ns/1ps
module ocs_props(input wire logic clk_in, srst_in, ce_in, s_axi_awvalid, s_axi_wvalid, s_axi_bvalid,
  s_axi_bready, s_axi_arvalid, s_axi_rvalid, s_axi_rready, wdt_en_in, slow_rc_en_out, sys_tick_out,
  prim_fall_in, sec_fall_in, slow_rc_fall_in, fast_osc_fall_in, wdt_clear_out, wdt_disable_out,
  input wire logic [31:0] s_axi_rdata);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // watchdog was held off right up to the clear, and the clear is a single pulse
  sequence s_done;
    $past(wdt_disable_out) ##1 !wdt_clear_out;
  endsequence
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped early");
  a_w_answer: assert property (ce_in && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write not answered");
  a_r_answer: assert property (ce_in && s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read not answered");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_rc_on: assert property (wdt_en_in [*3] |-> slow_rc_en_out)
    else $error("slow rc off");
  a_tick_cause: assert property (sys_tick_out |-> $past(prim_fall_in | sec_fall_in | slow_rc_fall_in | fast_osc_fall_in))
    else $error("tick without source fall");
  a_clear_end: assert property (wdt_clear_out |-> s_done)
    else $error("watchdog clear misplaced");
endmodule // ocs_props
bind ocs_clock_switch ocs_props i_props (.*);

// >>> tb/ocs_osc_model.sv
// strobe model of the four oscillators, one strobe per falling edge
`timescale 1ns/1ps
module ocs_osc_model(input wire logic clk_in, prim_en_in,
  output logic prim_fall_out, sec_fall_out, slow_fall_out, fast_fall_out);
  logic [4:0] cnt = 5'h00;  // shared phase counter
  always @(posedge clk_in) cnt <= cnt + 5'h01;
  assign fast_fall_out = cnt[0];  // fast source: one in 2
  assign prim_fall_out = prim_en_in && &cnt[1:0];  // crystal stops while disabled
  assign sec_fall_out  = &cnt[3:0];
  assign slow_fall_out = &cnt;  // slow rc: one in 32
endmodule // ocs_osc_model

// >>> tb/testbench.sv
// self-checking bench for ocs_clock_switch with the strobe model
`timescale 1ns/1ps
`include "ocs_regs.vh"
`define CK(n,e,g) begin checked++; if ((g) !== (e)) begin mismatches++; $display("wrong value %s exp %h got %h", n, e, g); end end
module testbench;
  logic clk_in = 0, srst_in = 1, ce_in = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, two_speed_en_in = 0, failsafe_monitor_enable_in = 0;
  logic pwrt_en_in = 1, wdt_en_in = 1, sleep_in = 0, wake_in = 0, prim_fail_in = 0, sec_fail_in = 0;
  logic sec_osc_en_in = 1, port_a_bit_six_out_in = 0, port_a_bit_six_oe_in = 0;
  logic port_a_bit_seven_out_in = 0, port_a_bit_seven_oe_in = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [2:0] primary_mode_in = `OCS_MODE_XT;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [5:0] tune_value_out;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sys_tick_out, cpu_hold_out;
  logic slow_rc_en_out, prim_osc_en_out, sec_osc_en_out, wdt_disable_out, wdt_clear_out, prim_fall_in;
  logic sec_fall_in, slow_rc_fall_in, fast_osc_fall_in, osc_input_pin_out, osc_input_pin_oe_out;
  logic osc_output_pin_out, osc_output_pin_oe_out, port_a_bit_six_rd_out, port_a_bit_seven_rd_out;
  wire osc_input_pin_in = osc_input_pin_oe_out ? osc_input_pin_out : 1'b1;  // pull-up when released
  wire osc_output_pin_in = osc_output_pin_oe_out ? osc_output_pin_out : 1'b1;
  int mismatches = 0, checked = 0;
  always #4 clk_in = ~clk_in;
  ocs_clock_switch #(.FSTABLE_CYC(20'd20)) i_dut (.*);
  ocs_osc_model i_osc (.clk_in, .prim_en_in(prim_osc_en_out), .prim_fall_out(prim_fall_in),
    .sec_fall_out(sec_fall_in), .slow_fall_out(slow_rc_fall_in), .fast_fall_out(fast_osc_fall_in));
  task wr(input [11:0] a, input [31:0] d);
    @(posedge clk_in);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    do @(negedge clk_in); while (!(s_axi_awready && s_axi_wready));
    @(posedge clk_in);
    s_axi_awvalid <= 0; s_axi_wvalid <= 0;
    do @(negedge clk_in); while (!s_axi_bvalid);
    @(posedge clk_in);
    s_axi_bready <= 0;
  endtask
  task rd(input [11:0] a, input [31:0] m, input [31:0] e, input [1:0] r);
    @(posedge clk_in);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do @(negedge clk_in); while (!s_axi_arready);
    @(posedge clk_in);
    s_axi_arvalid <= 0;
    do @(negedge clk_in); while (!s_axi_rvalid);
    `CK("read data", e, s_axi_rdata & m)
    `CK("read resp", r, s_axi_rresp)
    @(posedge clk_in);
    s_axi_rready <= 0;
  endtask
  // cycles between two system ticks
  task gap(input int e);
    int k;
    k = -1;
    repeat (99) begin
      @(negedge clk_in);
      if (k >= 0 || sys_tick_out === 1'b1) k++;
      if (k > 0 && sys_tick_out === 1'b1) break;
    end
    `CK("tick gap", e, k)
  endtask
  task sw;
    int k;
    for (k = 0; k < 9000 && wdt_clear_out !== 1'b1; k++) @(negedge clk_in);
    `CK("switch done", 1'b1, wdt_clear_out)
  endtask
  task t_start;
    sw;
    `CK("cpu hold", 1'b0, cpu_hold_out)
    rd(`OCS_ADDR_CTRL, 32'hFF, 32'h0C, `OCS_RESP_OKAY);
    rd(`OCS_ADDR_TUNE, 32'hFF, 32'h00, `OCS_RESP_OKAY);
  endtask
  task t_regs;
    wr(`OCS_ADDR_TUNE, 32'hFFFFFFE0);
    rd(`OCS_ADDR_TUNE, 32'hFFFFFFFF, 32'h20, `OCS_RESP_OKAY);
    `CK("tune out", 6'h20, tune_value_out)
    rd(12'h0F0, 32'hFFFFFFFF, 32'h0, `OCS_RESP_SLVERR);
  endtask
  task t_int;
    wr(`OCS_ADDR_CTRL, 32'h7E);
    rd(`OCS_ADDR_CTRL, 32'hFF, 32'h72, `OCS_RESP_OKAY);
    sw;
    repeat (20) @(posedge clk_in);
    rd(`OCS_ADDR_CTRL, 32'hFF, 32'h76, `OCS_RESP_OKAY);
    gap(2);
    wr(`OCS_ADDR_CTRL, 32'h62);
    sw;
    gap(4);
  endtask
  task t_pri;
    wr(`OCS_ADDR_CTRL, 32'h00);
    sw;
    rd(`OCS_ADDR_CTRL, 32'hFB, 32'h08, `OCS_RESP_OKAY);
    gap(4);
  endtask
  task t_fail;
    @(posedge clk_in);
    failsafe_monitor_enable_in <= 1; prim_fail_in <= 1;
    @(posedge clk_in);
    prim_fail_in <= 0;
    sw;
    gap(32);
  endtask
  task t_pins;
    @(posedge clk_in);
    primary_mode_in <= `OCS_MODE_INT_IO;
    port_a_bit_six_out_in <= 1;
    port_a_bit_six_oe_in <= 1;
    repeat (3) @(negedge clk_in);
    `CK("osc out pin", 2'h3, {osc_output_pin_oe_out, osc_output_pin_out})
    `CK("port six read", 1'b1, port_a_bit_six_rd_out)
    `CK("port seven read", 1'b1, port_a_bit_seven_rd_out)
    @(posedge clk_in);
    primary_mode_in <= `OCS_MODE_INT_CLOCK_OUTPUT;
    repeat (3) @(negedge clk_in);
    `CK("clkout enable", 1'b1, osc_output_pin_oe_out)
    `CK("port six idle", 1'b0, port_a_bit_six_rd_out)
  endtask
  task test_done;
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    srst_in <= 0;
    t_start; t_regs; t_int; t_pri; t_fail; t_pins;
    test_done;
  end
  initial begin
    repeat (30000) @(posedge clk_in);
    mismatches++;
    test_done;
  end
endmodule // testbench
